// *** pif_map.svh ***
// register map and field constants of the peripheral flag bank
// assumes inclusion by bare name from package and modules
`ifndef PIF_MAP_SVH
`define PIF_MAP_SVH
// byte offsets on the register bus
`define PIF_OFS_FLAGS_ONE   8'h00
`define PIF_OFS_FLAGS_TWO   8'h04
`define PIF_OFS_FLAGS_THREE 8'h08
`define PIF_OFS_FLAGS_FOUR  8'h0c
`define PIF_OFS_IRQ_MASK1   8'h10
`define PIF_OFS_IRQ_MASK2   8'h14
`define PIF_OFS_IRQ_MASK3   8'h18
`define PIF_OFS_IRQ_MASK4   8'h1c
`define PIF_OFS_IRQ_CTRL    8'h20
// implemented bits per flag register
`define PIF_IMPL_ONE   8'hff
`define PIF_IMPL_TWO   8'hf9
`define PIF_IMPL_THREE 8'h3a
`define PIF_IMPL_FOUR  8'h03
// software-writable bits of flag register one (rx, tx are read-only)
`define PIF_WR_ONE     8'hcf
// variant-only bit of flag register two (capcomp2)
`define PIF_BIG_TWO    8'h01
// control register fields
`define PIF_CTRL_PERIPH_EN 0
`define PIF_CTRL_GLOBAL_EN 1
// reset value of every flag and mask
`define PIF_RST_BYTE   8'h00
`define PIF_ADDR_W     8
`define PIF_RESP_OKAY  2'b00
`define PIF_RESP_SLVERR 2'b10
`endif

// *** pif_pkg.sv ***
// types shared by the peripheral flag bank
// assumes pif_map.svh is on the include path
`include "pif_map.svh"
package pif_pkg;
  typedef logic [7:0] pif_byte_t;
  // hardware event strobes, one bit per flag, per register
  typedef struct packed {
    pif_byte_t four;
    pif_byte_t three;
    pif_byte_t two;
    pif_byte_t one;
  } pif_bank_s;
  typedef enum logic [1:0] {
    PIF_IDLE = 2'b00,
    PIF_RESP = 2'b01
  } pif_bus_e;
  // axi write-side request as seen by the flag bank
  typedef struct packed {
    logic      wr;
    logic      w1c;
    logic [3:0] sel;
    pif_byte_t data;
  } pif_wreq_s;
endpackage

// *** pif_flag_reg.sv ***
// one 8-bit flag register: hardware set, software write, set wins
// assumes set strobes and write requests are synchronous to aclk
`timescale 1ns/10ps
`default_nettype none
`include "pif_map.svh"
module pif_flag_reg
  import pif_pkg::*;
#(
  parameter logic [7:0] IMPL = 8'hff,
  parameter logic [7:0] WMASK = 8'hff
) (
  input  wire logic      aclk,
  input  wire logic      aresetn,
  input  wire logic [7:0] set_i,
  input  wire logic      wr_i,
  input  wire logic [7:0] wdata_i,
  output logic     [7:0] flags_o
);
  typedef struct packed {
    logic [7:0] flags;
  } pif_freg_s;
  pif_freg_s st_q;
  pif_freg_s st_d;
  // ==========================================================
  // next state
  // writes touch only writable bits; a set beats a clear
  always_comb begin
    st_d = st_q;
    if (wr_i) begin
      st_d.flags = (st_q.flags & ~WMASK) | (wdata_i & WMASK);
    end
    st_d.flags = (st_d.flags | set_i) & IMPL;
  end
  // ==========================================================
  // register; every reset kind clears all flags
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q.flags <= `PIF_RST_BYTE;
    end else begin
      st_q <= st_d;
    end
  end
  assign flags_o = st_q.flags;
endmodule
`default_nettype wire

// *** pif_axil_slave.sv ***
// axi4-lite slave front end: one write and one read at a time
// assumes a single master on aclk; answers reads one cycle and writes two cycles after acceptance
`timescale 1ns/10ps
`default_nettype none
`include "pif_map.svh"
module pif_axil_slave
  import pif_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [7:0] awaddr,
  input  wire logic       awvalid,
  output logic            awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0] wstrb,
  input  wire logic       wvalid,
  output logic            wready,
  output logic [1:0]      bresp,
  output logic            bvalid,
  input  wire logic       bready,
  input  wire logic [7:0] araddr,
  input  wire logic       arvalid,
  output logic            arready,
  output logic [31:0]     rdata,
  output logic [1:0]      rresp,
  output logic            rvalid,
  input  wire logic       rready,
  output logic            wr_o,
  output logic [7:0]      waddr_o,
  output logic [7:0]      wbyte_o,
  input  wire logic       wok_i,
  output logic [7:0]      raddr_o,
  output logic            rd_o,
  input  wire logic [7:0] rbyte_i,
  input  wire logic       rok_i
);
  typedef struct packed {
    logic        aw_got;
    logic        w_got;
    logic [7:0]  aw;
    logic [7:0]  wd;
    logic        wl0;
    pif_bus_e    wst;
    logic [1:0]  bresp;
    pif_bus_e    rst;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        awrdy;
    logic        wrdy;
    logic        bvld;
    logic        arrdy;
    logic        rvld;
  } pif_axs_s;
  // readies up, responses idle, out of reset
  localparam pif_axs_s AXS_RST = '{
    aw_got: 1'b0, w_got: 1'b0, aw: 8'h00, wd: 8'h00, wl0: 1'b0,
    wst: PIF_IDLE, bresp: 2'b00, rst: PIF_IDLE, rdata: 32'h0,
    rresp: 2'b00, awrdy: 1'b1, wrdy: 1'b1, bvld: 1'b0, arrdy: 1'b1,
    rvld: 1'b0
  };
  pif_axs_s st_q;
  pif_axs_s st_d;
  logic fire_w;
  // ==========================================================
  // channel handshakes; address and data accepted in either order
  always_comb begin
    st_d = st_q;
    fire_w = 1'b0;
    if (st_q.wst == PIF_IDLE) begin
      if (awvalid && !st_q.aw_got) begin
        st_d.aw_got = 1'b1;
        st_d.aw = awaddr;
      end
      if (wvalid && !st_q.w_got) begin
        st_d.w_got = 1'b1;
        st_d.wd = wdata[7:0];
        st_d.wl0 = wstrb[0]; // only lane 0 holds data
      end
      if (st_q.aw_got && st_q.w_got) begin
        fire_w = st_q.wl0;
        st_d.aw_got = 1'b0;
        st_d.w_got = 1'b0;
        st_d.wst = PIF_RESP;
        st_d.bresp = wok_i ? `PIF_RESP_OKAY : `PIF_RESP_SLVERR;
      end
    end else if (bready) begin
      st_d.wst = PIF_IDLE;
    end
    // read: take address, answer next cycle
    if (st_q.rst == PIF_IDLE) begin
      if (arvalid) begin
        st_d.rst = PIF_RESP;
        st_d.rdata = {24'h000000, rbyte_i};
        st_d.rresp = rok_i ? `PIF_RESP_OKAY : `PIF_RESP_SLVERR;
      end
    end else if (rready) begin
      st_d.rst = PIF_IDLE;
    end
    // handshake outputs registered so the ports come from flops
    st_d.awrdy = (st_d.wst == PIF_IDLE) && !st_d.aw_got;
    st_d.wrdy  = (st_d.wst == PIF_IDLE) && !st_d.w_got;
    st_d.bvld  = (st_d.wst == PIF_RESP);
    st_d.arrdy = (st_d.rst == PIF_IDLE);
    st_d.rvld  = (st_d.rst == PIF_RESP);
  end
  // ==========================================================
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= AXS_RST;
    end else begin
      st_q <= st_d;
    end
  end
  // ready and valid outputs come straight from flops
  assign awready = st_q.awrdy;
  assign wready  = st_q.wrdy;
  assign bvalid  = st_q.bvld;
  assign bresp   = st_q.bresp;
  assign arready = st_q.arrdy;
  assign rvalid  = st_q.rvld;
  assign rdata   = st_q.rdata;
  assign rresp   = st_q.rresp;
  assign wr_o    = fire_w;
  assign waddr_o = st_q.aw;
  assign wbyte_o = st_q.wd;
  assign raddr_o = araddr;
  assign rd_o    = arvalid && (st_q.rst == PIF_IDLE);
endmodule
`default_nettype wire

// *** pif_flag_bank.sv ***
// Overview of operation
// - flags set by events regardless of enables
// - register one layout, gate down to overflow
// - rx and tx flags are read-only
// - all flags reset to zero
// - one means pending, zero means none
// - register two layout, osc fail to capcomp2
// - register two bits 2,1 read zero
// - register three layout, other bits zero
// - registers three, four, capcomp2 variant-only
// - register four: collision2 bit1, port2 bit0
// - peripheral enable gates every flag request
//
// peripheral interrupt flag bank with axi4-lite register access
// assumes event strobes are one-cycle pulses or levels on aclk
//
// Added by the designer: the address map and register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
`include "pif_map.svh"
module pif_flag_bank
  import pif_pkg::*;
#(
  parameter bit BIG_VARIANT = 1'b1
) (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // event strobes from peripherals, laid out as the flag registers
  input  wire pif_bank_s  events,
  // axi4-lite
  input  wire logic [7:0] s_axi_awaddr,
  input  wire logic       s_axi_awvalid,
  output logic            s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0] s_axi_wstrb,
  input  wire logic       s_axi_wvalid,
  output logic            s_axi_wready,
  output logic [1:0]      s_axi_bresp,
  output logic            s_axi_bvalid,
  input  wire logic       s_axi_bready,
  input  wire logic [7:0] s_axi_araddr,
  input  wire logic       s_axi_arvalid,
  output logic            s_axi_arready,
  output logic [31:0]     s_axi_rdata,
  output logic [1:0]      s_axi_rresp,
  output logic            s_axi_rvalid,
  input  wire logic       s_axi_rready,
  // interrupt request toward the processor
  output logic            irq
);
  // ==========================================================
  // variant masks
  localparam logic [7:0] IMPL_TWO = BIG_VARIANT ? `PIF_IMPL_TWO
                                  : (`PIF_IMPL_TWO & ~`PIF_BIG_TWO);
  localparam logic [7:0] IMPL_THREE = BIG_VARIANT ? `PIF_IMPL_THREE
                                    : 8'h00;
  localparam logic [7:0] IMPL_FOUR = BIG_VARIANT ? `PIF_IMPL_FOUR
                                   : 8'h00;

  typedef struct packed {
    pif_bank_s  mask;
    logic [1:0] ctrl;
    logic       irq;
  } pif_top_s;
  pif_top_s st_q;
  pif_top_s st_d;

  logic       wr;
  logic [7:0] waddr;
  logic [7:0] wbyte;
  logic       rd;
  logic [7:0] raddr;
  logic [7:0] rbyte;
  logic       rok;
  logic       wok;
  pif_bank_s  flags;
  pif_bank_s  pend;

  // ==========================================================
  // decode helpers
  function automatic logic mapped(input logic [7:0] a);
    case (a)
      `PIF_OFS_FLAGS_ONE, `PIF_OFS_FLAGS_TWO, `PIF_OFS_FLAGS_THREE,
      `PIF_OFS_FLAGS_FOUR, `PIF_OFS_IRQ_MASK1, `PIF_OFS_IRQ_MASK2,
      `PIF_OFS_IRQ_MASK3, `PIF_OFS_IRQ_MASK4,
      `PIF_OFS_IRQ_CTRL: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  endfunction

  function automatic logic hit(input logic w, input logic [7:0] a,
                               input logic [7:0] o);
    hit = w && (a == o);
  endfunction

  // ==========================================================
  // bus front end
  pif_axil_slave u_bus (
    .aclk    (aclk),
    .aresetn (aresetn),
    .awaddr  (s_axi_awaddr),
    .awvalid (s_axi_awvalid),
    .awready (s_axi_awready),
    .wdata   (s_axi_wdata),
    .wstrb   (s_axi_wstrb),
    .wvalid  (s_axi_wvalid),
    .wready  (s_axi_wready),
    .bresp   (s_axi_bresp),
    .bvalid  (s_axi_bvalid),
    .bready  (s_axi_bready),
    .araddr  (s_axi_araddr),
    .arvalid (s_axi_arvalid),
    .arready (s_axi_arready),
    .rdata   (s_axi_rdata),
    .rresp   (s_axi_rresp),
    .rvalid  (s_axi_rvalid),
    .rready  (s_axi_rready),
    .wr_o    (wr),
    .waddr_o (waddr),
    .wbyte_o (wbyte),
    .wok_i   (wok),
    .raddr_o (raddr),
    .rd_o    (rd),
    .rbyte_i (rbyte),
    .rok_i   (rok)
  );

  // ==========================================================
  // flag registers; events set flags whatever the enables say
  pif_flag_reg #(.IMPL(`PIF_IMPL_ONE), .WMASK(`PIF_WR_ONE)) u_one (
    .aclk    (aclk),
    .aresetn (aresetn),
    .set_i   (events.one),
    .wr_i    (hit(wr, waddr, `PIF_OFS_FLAGS_ONE)),
    .wdata_i (wbyte),
    .flags_o (flags.one)
  );
  pif_flag_reg #(.IMPL(IMPL_TWO), .WMASK(IMPL_TWO)) u_two (
    .aclk    (aclk),
    .aresetn (aresetn),
    .set_i   (events.two),
    .wr_i    (hit(wr, waddr, `PIF_OFS_FLAGS_TWO)),
    .wdata_i (wbyte),
    .flags_o (flags.two)
  );
  pif_flag_reg #(.IMPL(IMPL_THREE), .WMASK(IMPL_THREE)) u_three (
    .aclk    (aclk),
    .aresetn (aresetn),
    .set_i   (events.three),
    .wr_i    (hit(wr, waddr, `PIF_OFS_FLAGS_THREE)),
    .wdata_i (wbyte),
    .flags_o (flags.three)
  );
  pif_flag_reg #(.IMPL(IMPL_FOUR), .WMASK(IMPL_FOUR)) u_four (
    .aclk    (aclk),
    .aresetn (aresetn),
    .set_i   (events.four),
    .wr_i    (hit(wr, waddr, `PIF_OFS_FLAGS_FOUR)),
    .wdata_i (wbyte),
    .flags_o (flags.four)
  );

  // ==========================================================
  // enables, control and interrupt request
  // software should clear stale flags before setting a mask bit,
  // otherwise the request rises at once
  assign pend = flags & st_q.mask;

  always_comb begin
    st_d = st_q;
    if (hit(wr, waddr, `PIF_OFS_IRQ_MASK1)) st_d.mask.one = wbyte;
    if (hit(wr, waddr, `PIF_OFS_IRQ_MASK2)) begin
      st_d.mask.two = wbyte & IMPL_TWO;
    end
    if (hit(wr, waddr, `PIF_OFS_IRQ_MASK3)) begin
      st_d.mask.three = wbyte & IMPL_THREE;
    end
    if (hit(wr, waddr, `PIF_OFS_IRQ_MASK4)) begin
      st_d.mask.four = wbyte & IMPL_FOUR;
    end
    if (hit(wr, waddr, `PIF_OFS_IRQ_CTRL)) st_d.ctrl = wbyte[1:0];
    // no peripheral request without both peripheral and global enable
    st_d.irq = st_q.ctrl[`PIF_CTRL_PERIPH_EN]
             && st_q.ctrl[`PIF_CTRL_GLOBAL_EN] && (|pend);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
  assign irq = st_q.irq;

  // ==========================================================
  // read mux; unimplemented bits read zero
  always_comb begin
    rbyte = 8'h00;
    case (raddr)
      `PIF_OFS_FLAGS_ONE:   rbyte = flags.one;
      `PIF_OFS_FLAGS_TWO:   rbyte = flags.two;
      `PIF_OFS_FLAGS_THREE: rbyte = flags.three;
      `PIF_OFS_FLAGS_FOUR:  rbyte = flags.four;
      `PIF_OFS_IRQ_MASK1:   rbyte = st_q.mask.one;
      `PIF_OFS_IRQ_MASK2:   rbyte = st_q.mask.two;
      `PIF_OFS_IRQ_MASK3:   rbyte = st_q.mask.three;
      `PIF_OFS_IRQ_MASK4:   rbyte = st_q.mask.four;
      `PIF_OFS_IRQ_CTRL:    rbyte = {6'h00, st_q.ctrl};
      default:              rbyte = 8'h00;
    endcase
  end
  // unmapped addresses answer slverr
  assign rok = mapped(raddr) && rd;
  assign wok = mapped(waddr);
endmodule
`default_nettype wire

// *** pif_evt_src.sv ***
// event source model: peripherals that raise flag events
// assumes strobe requests from the bench, one aclk domain
`timescale 1ns/10ps
`default_nettype none
module pif_evt_src
  import pif_pkg::*;
(
  input  wire logic      aclk,
  input  wire logic      aresetn,
  input  wire pif_bank_s fire,
  output pif_bank_s      events
);
  // ==================================================
  // event strobes
  // one-cycle pulses, raised with no regard to any enable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      events <= '0;
    end else begin
      events <= fire;
    end
  end
endmodule
`default_nettype wire

// *** pif_flag_bank_monitor.sv ***
// port checker of the peripheral flag bank
// assumes binding into pif_flag_bank, one clock aclk
`timescale 1ns/10ps
`default_nettype none
module pif_flag_bank_monitor
  import pif_pkg::*;
#(
  parameter bit BIG_VARIANT = 1'b1
) (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        irq
);
  // ==================================================
  // shadow state
  logic [7:0] ra_q;
  logic [1:0] ctl_q;
  logic [1:0] off_q;
  logic       hs;
  assign hs = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  // tracks only writes whose address and data come together
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ra_q <= 8'h00;
      ctl_q <= 2'h0;
      off_q <= 2'h3;
    end else begin
      if (s_axi_arvalid && s_axi_arready) ra_q <= s_axi_araddr;
      if (hs && s_axi_awaddr == 8'h20 && s_axi_wstrb[0]) begin
        ctl_q <= s_axi_wdata[1:0];
      end
      // saturating age of the last time both enables were on
      off_q <= (ctl_q == 2'h3) ? 2'h0
             : ((off_q == 2'h3) ? off_q : off_q + 2'h1);
    end
  end
  // ==================================================
  // assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_RST_IRQ: assert property ($rose(aresetn) |-> !irq)
    else $error("irq high after reset");
  AST_RST_BUS: assert property (
    $rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid)
    else $error("response pending after reset");
  AST_IRQ_GATE: assert property (irq |-> off_q != 2'h3)
    else $error("irq without both enables");
  AST_TWO_GAP: assert property (
    s_axi_rvalid && ra_q == 8'h04 |-> s_axi_rdata[2:1] == 2'b00)
    else $error("flags two gap bits set");
  AST_THREE_GAP: assert property (
    s_axi_rvalid && ra_q == 8'h08 |-> (s_axi_rdata[7:0] & 8'hc5) == 8'h00)
    else $error("flags three gap bits set");
  AST_FOUR_GAP: assert property (
    s_axi_rvalid && ra_q == 8'h0c |-> s_axi_rdata[7:2] == 6'h00)
    else $error("flags four gap bits set");
  AST_VARIANT: assert property (
    s_axi_rvalid && !BIG_VARIANT && ra_q[3] |-> s_axi_rdata == 32'h0)
    else $error("variant flags visible");
  AST_READ_TIME: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_WRITE_TIME: assert property (hs |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  cover property (irq);
  cover property (s_axi_rvalid && ra_q == 8'h08 && s_axi_rdata != 32'h0);
  cover property (hs && s_axi_awaddr == 8'h20);
endmodule
bind pif_flag_bank pif_flag_bank_monitor #(.BIG_VARIANT(BIG_VARIANT))
  pif_flag_bank_monitor_i (
  .aclk          (aclk),
  .aresetn       (aresetn),
  .s_axi_awaddr  (s_axi_awaddr),
  .s_axi_awvalid (s_axi_awvalid),
  .s_axi_awready (s_axi_awready),
  .s_axi_wdata   (s_axi_wdata),
  .s_axi_wstrb   (s_axi_wstrb),
  .s_axi_wvalid  (s_axi_wvalid),
  .s_axi_wready  (s_axi_wready),
  .s_axi_bvalid  (s_axi_bvalid),
  .s_axi_bready  (s_axi_bready),
  .s_axi_araddr  (s_axi_araddr),
  .s_axi_arvalid (s_axi_arvalid),
  .s_axi_arready (s_axi_arready),
  .s_axi_rdata   (s_axi_rdata),
  .s_axi_rvalid  (s_axi_rvalid),
  .irq           (irq)
);
`default_nettype wire

// *** tb.sv ***
// bench of the flag bank: registers, events, interrupt
// assumes the bank, its checker and the event source model
`timescale 1ns/10ps
`default_nettype none
module tb;
  import pif_pkg::*;
  // ==================================================
  // signals
  localparam logic [1:0] OK = 2'b00;
  localparam logic [1:0] ERR = 2'b10;
  localparam logic [7:0] WMASK [4] = '{8'hcf, 8'hf9, 8'h3a, 8'h03};
  localparam logic [7:0] IMASK [4] = '{8'hff, 8'hf9, 8'h3a, 8'h03};
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  pif_bank_s   fire = '0;
  pif_bank_s   events;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  int          miscompares = 0;
  int          checks = 0;
  int          cycles = 0;
  always #20 aclk = ~aclk;
  pif_evt_src pif_evt_src_i (.aclk(aclk), .aresetn(aresetn), .fire(fire),
    .events(events));
  pif_flag_bank pif_flag_bank_i (.aclk(aclk), .aresetn(aresetn),
    .events(events), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .irq(irq));
  // ==================================================
  // verdict and comparisons
  task automatic stop_test();
    if (miscompares == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic cmp_d(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: data %h not %h", $time, got, exp);
    end
  endtask
  task automatic cmp_r(input logic [1:0] got, input logic [1:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: resp %b not %b", $time, got, exp);
    end
  endtask
  task automatic cmp_b(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: irq %b not %b", $time, got, exp);
    end
  endtask
  // hang guard, far above the few hundred cycles the run needs
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      stop_test();
    end
  end
  // ==================================================
  // bus and event drivers
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
    input logic [3:0] s, input pif_bank_s ev, input logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    fire <= ev;
    do begin
      @(posedge aclk);
      fire <= '0;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    cmp_r(bresp, r);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e,
    input logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    cmp_d(rdata, {24'h0, e});
    cmp_r(rresp, r);
  endtask
  task automatic pulse(input pif_bank_s ev);
    @(posedge aclk);
    fire <= ev;
    @(posedge aclk);
    fire <= '0;
    repeat (3) @(posedge aclk);
  endtask
  task automatic do_reset();
    aresetn <= 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
  endtask
  // ==================================================
  // scenarios
  task automatic t_reset();
    for (int a = 0; a <= 32; a += 4) rd(8'(a), 8'h00, OK);
    cmp_b(irq, 1'b0);
  endtask
  task automatic t_access();
    for (int i = 0; i < 4; i++) begin
      wr(8'(4 * i), 8'hff, 4'hf, '0, OK);
      rd(8'(4 * i), WMASK[i], OK);
      wr(8'(4 * i), 8'h00, 4'hf, '0, OK);
      rd(8'(4 * i), 8'h00, OK);
      // enables share the flag layout, gaps included
      wr(8'(16 + 4 * i), 8'hff, 4'hf, '0, OK);
      rd(8'(16 + 4 * i), IMASK[i], OK);
      wr(8'(16 + 4 * i), 8'h00, 4'hf, '0, OK);
      rd(8'(16 + 4 * i), 8'h00, OK);
    end
  endtask
  task automatic t_events();
    logic [7:0] st;
    st = 8'h00;
    for (int b = 0; b < 8; b++) begin
      pulse(pif_bank_s'({4{8'h01 << b}}));
      cmp_b(irq, 1'b0);
      for (int i = 0; i < 4; i++) begin
        rd(8'(4 * i), ((8'h01 << b) & IMASK[i]) | (i == 0 ? st : 8'h00),
           OK);
        wr(8'(4 * i), 8'h00, 4'hf, '0, OK);
      end
      st = st | ((8'h01 << b) & 8'h30);
    end
    rd(8'h00, 8'h30, OK);
  endtask
  task automatic t_race();
    wr(8'h04, 8'h00, 4'hf, pif_bank_s'(32'h8000), OK);
    rd(8'h04, 8'h80, OK);
    wr(8'h04, 8'h01, 4'hf, pif_bank_s'(32'h0800), OK);
    rd(8'h04, 8'h09, OK);
    wr(8'h04, 8'h00, 4'hf, '0, OK);
  endtask
  task automatic t_irq();
    pulse(pif_bank_s'(32'h4000));
    // stale flag cleared before its enable goes on
    wr(8'h04, 8'h00, 4'hf, '0, OK);
    wr(8'h14, 8'h40, 4'hf, '0, OK);
    for (int c = 1; c < 4; c++) begin
      wr(8'h20, 8'(c), 4'hf, '0, OK);
      pulse(pif_bank_s'(32'h4000));
      cmp_b(irq, c == 3);
    end
    rd(8'h20, 8'h03, OK);
    wr(8'h14, 8'h00, 4'hf, '0, OK);
    pulse('0);
    cmp_b(irq, 1'b0);
    // a flag left set raises the request once its enable is on
    wr(8'h14, 8'h40, 4'hf, '0, OK);
    pulse('0);
    cmp_b(irq, 1'b1);
    wr(8'h04, 8'h00, 4'hf, '0, OK);
    pulse('0);
    cmp_b(irq, 1'b0);
  endtask
  task automatic t_refuse();
    wr(8'h24, 8'hff, 4'hf, '0, ERR);
    rd(8'h24, 8'h00, ERR);
    wr(8'h00, 8'hff, 4'h0, '0, OK);
    rd(8'h00, 8'h00, OK);
  endtask
  // main sequence; the second reset follows stuck rx and tx flags
  initial begin
    do_reset();
    t_reset();
    t_access();
    t_events();
    do_reset();
    t_reset();
    t_race();
    t_irq();
    t_refuse();
    stop_test();
  end
endmodule
`default_nettype wire
